// ==== rtl/rvc_top.sv ====
// Register slice for the second linear regulator and the neighbouring
// switch or third-regulator control register.
// Assumes a host-side bridge delivers decoded byte writes and reads,
// and that the unlock scheme is resolved outside into i_wr_permit.
`timescale 1ns/1ps
`include "rvc_regs.svh"

module rvc_top #(
	parameter rvc_pkg::rvc_byte_t SW3_RESET = `RVC_SW3_CTRL_RESET
) (
	input  wire                 i_ref_clk,
	input  wire                 i_rst_n,
	input  wire                 i_wr_en,
	input  wire                 i_wr_permit,
	input  wire [7:0]           i_wr_addr,
	input  wire [7:0]           i_wr_data,
	input  wire                 i_rd_en,
	input  wire [7:0]           i_rd_addr,
	input  wire [11:0]          i_converter3_mv,
	output logic [7:0]          o_rd_data,
	output logic                o_rd_valid,
	output logic                o_tracking,
	output logic [5:0]          o_regulator2_voltage_code,
	output logic [11:0]         o_regulator2_mv,
	output logic [7:0]          o_switch_or_regulator3_ctrl
);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic                 rst_meta_reg;
	logic                 rst_n_reg;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	function automatic logic hits(input logic [7:0] a, input logic [7:0] o);
		hits = (a == o);
	endfunction

	rvc_pkg::rvc_byte_t   aux_regulator_voltage_ctrl_reg;
	rvc_pkg::rvc_byte_t   switch_or_regulator3_ctrl_reg;
	rvc_pkg::rvc_mv_t     decoded_mv;
	rvc_pkg::rvc_mv_t     setpoint_next;
	rvc_pkg::rvc_byte_t   rd_next;
	logic                 wr_ok;

	// Unlock is judged outside; a write without it is dropped silently
	assign wr_ok = i_wr_en && i_wr_permit;

	// ------------------------------------------------------------------
	// Second-regulator control
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			aux_regulator_voltage_ctrl_reg <= `RVC_AUX_REG2_RESET;
		end else if (wr_ok && hits(i_wr_addr, `RVC_AUX_REG2_OFFSET)) begin
			aux_regulator_voltage_ctrl_reg <= {1'b0, i_wr_data[6:0]};
		end
	end

	// ------------------------------------------------------------------
	// Switch or third-regulator control
	// ------------------------------------------------------------------
	// Field layout lives downstream; stored whole
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			switch_or_regulator3_ctrl_reg <= SW3_RESET;
		end else if (wr_ok && hits(i_wr_addr, `RVC_SW3_CTRL_OFFSET)) begin
			switch_or_regulator3_ctrl_reg <= i_wr_data;
		end
	end

	// ------------------------------------------------------------------
	// Setpoint
	// ------------------------------------------------------------------
	rvc_second_linear_regulator_decode u_decode (
		.i_code (aux_regulator_voltage_ctrl_reg[`RVC_CODE_MSB:`RVC_CODE_LSB]),
		.o_mv   (decoded_mv)
	);

	always_comb begin
		if (aux_regulator_voltage_ctrl_reg[`RVC_TRACK_BIT]) begin
			setpoint_next = i_converter3_mv;
		end else begin
			setpoint_next = decoded_mv;
		end
	end

	// Registered so the analog side never sees decode glitches
	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_regulator2_mv <= `RVC_MV_MAX;
		end else begin
			o_regulator2_mv <= setpoint_next;
		end
	end

	assign o_tracking = aux_regulator_voltage_ctrl_reg[`RVC_TRACK_BIT];
	assign o_regulator2_voltage_code =
		aux_regulator_voltage_ctrl_reg[`RVC_CODE_MSB:`RVC_CODE_LSB];
	assign o_switch_or_regulator3_ctrl = switch_or_regulator3_ctrl_reg;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	always_comb begin
		if (hits(i_rd_addr, `RVC_AUX_REG2_OFFSET)) begin
			rd_next = aux_regulator_voltage_ctrl_reg;
		end else if (hits(i_rd_addr, `RVC_SW3_CTRL_OFFSET)) begin
			rd_next = switch_or_regulator3_ctrl_reg;
		end else begin
			rd_next = 8'h00;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_rd_data  <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
			if (i_rd_en) begin
				o_rd_data <= rd_next;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!rst_n_reg);

	sequence s_aux_wr_ok;
		i_wr_en && i_wr_permit && i_wr_addr == `RVC_AUX_REG2_OFFSET;
	endsequence

	sequence s_aux_rd;
		i_rd_en && i_rd_addr == `RVC_AUX_REG2_OFFSET;
	endsequence

	sequence s_sw3_rd;
		i_rd_en && i_rd_addr == `RVC_SW3_CTRL_OFFSET;
	endsequence

	AST_RESET_VALUE: assert property (
		$rose(rst_n_reg) |->
			aux_regulator_voltage_ctrl_reg == `RVC_AUX_REG2_RESET)
		else $error("aux register not at reset value");

	AST_PERMITTED_WRITE: assert property (
		s_aux_wr_ok |=> aux_regulator_voltage_ctrl_reg[6:0] ==
			$past(i_wr_data[6:0]))
		else $error("permitted write not committed");

	AST_RESERVED_READ: assert property (
		s_aux_rd ##1 o_rd_valid |-> o_rd_data[7] == 1'b0)
		else $error("reserved bit read as one");

	AST_CODE_SETPOINT: assert property (
		!o_tracking |=> o_regulator2_mv == $past(decoded_mv))
		else $error("setpoint not from voltage code");

	AST_TRACK_SETPOINT: assert property (
		o_tracking |=> o_regulator2_mv == $past(i_converter3_mv))
		else $error("setpoint not tracking converter");

	AST_CLAMP: assert property (
		!o_tracking && o_regulator2_voltage_code >= `RVC_CLAMP_CODE
		|=> o_regulator2_mv == `RVC_MV_MAX)
		else $error("upper code not clamped");

	AST_SW3_WRITE: assert property (
		i_wr_en && i_wr_permit && i_wr_addr == `RVC_SW3_CTRL_OFFSET
		|=> o_switch_or_regulator3_ctrl == $past(i_wr_data))
		else $error("switch register write lost");

	AST_LOCKED_DISCARD: assert property (
		i_wr_en && !i_wr_permit |=>
			$stable(aux_regulator_voltage_ctrl_reg) &&
			$stable(switch_or_regulator3_ctrl_reg))
		else $error("locked write changed a register");

	// ------------------------------------------------------------------
	// Read-back, reset-value, offset and tracking-bit checks
	// ------------------------------------------------------------------
	// Reads sample the register before any same-cycle write lands
	AST_AUX_READBACK: assert property (
		s_aux_rd |=> o_rd_valid &&
			o_rd_data == $past(aux_regulator_voltage_ctrl_reg))
		else $error("aux register read back wrong");

	AST_SW3_READBACK: assert property (
		s_sw3_rd |=> o_rd_valid &&
			o_rd_data == $past(switch_or_regulator3_ctrl_reg))
		else $error("switch register read back wrong");

	AST_SW3_RESET_VALUE: assert property (
		$rose(rst_n_reg) |->
			switch_or_regulator3_ctrl_reg == SW3_RESET)
		else $error("switch register not at reset value");

	// A stray offset must not alias onto either control register
	AST_OTHER_OFFSET: assert property (
		i_wr_en && !hits(i_wr_addr, `RVC_AUX_REG2_OFFSET) &&
			!hits(i_wr_addr, `RVC_SW3_CTRL_OFFSET) |=>
			$stable(aux_regulator_voltage_ctrl_reg) &&
			$stable(switch_or_regulator3_ctrl_reg))
		else $error("write to other offset changed a register");

	AST_TRACK_FOLLOWS_WRITE: assert property (
		s_aux_wr_ok |=> o_tracking == $past(i_wr_data[`RVC_TRACK_BIT]))
		else $error("tracking bit not committed");

endmodule // rvc_top

// ==== rtl/rvc_regs.svh ====
// Offsets, reset values, field positions and setpoints of the
// second-regulator register slice.
// Assumes a single 250 MHz register clock; included by rvc_top and the
// voltage-code decoder.
`ifndef RVC_REGS_SVH
`define RVC_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define RVC_AUX_REG2_OFFSET   8'h13
`define RVC_SW3_CTRL_OFFSET   8'h14

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define RVC_AUX_REG2_RESET    8'h38
`define RVC_SW3_CTRL_RESET    8'h00
`define RVC_RESERVED_BIT      7
`define RVC_TRACK_BIT         6
`define RVC_CODE_MSB          5
`define RVC_CODE_LSB          0
`define RVC_CLAMP_CODE        6'h38

// ----------------------------------------------------------------------
// Setpoints in millivolts
// ----------------------------------------------------------------------
`define RVC_MV_BASE           12'h384
`define RVC_MV_MAX            12'hce4

`endif

// ==== rtl/rvc_pkg.sv ====
// Types shared by the second-regulator register slice.
// Assumes rvc_regs.svh supplies all numeric constants.
package rvc_pkg;

	typedef logic [7:0]  rvc_byte_t;
	typedef logic [5:0]  rvc_code_t;
	typedef logic [11:0] rvc_mv_t;

endpackage

// ==== rtl/rvc_second_linear_regulator_decode.sv ====
// Voltage-code decoder of the second linear regulator, in millivolts.
// Assumes a 6-bit code and the constants of rvc_regs.svh.
`timescale 1ns/1ps
`include "rvc_regs.svh"

module rvc_second_linear_regulator_decode (
	input  wire rvc_pkg::rvc_code_t i_code,
	output rvc_pkg::rvc_mv_t        o_mv
);

	// Piecewise table; steps widen with the code
	function automatic rvc_pkg::rvc_mv_t decode_mv(
		input rvc_pkg::rvc_code_t code
	);
		rvc_pkg::rvc_mv_t low4;
		low4 = {8'h00, code[3:0]};
		if (code < 6'h10) begin
			decode_mv = `RVC_MV_BASE + 12'(low4 * 12'h019);
		end else if (code < 6'h18) begin
			decode_mv = 12'h514 + 12'(low4 * 12'h019);
		end else if (code < 6'h20) begin
			decode_mv = 12'h5dc + 12'((low4 - 12'h008) * 12'h032);
		end else if (code < 6'h30) begin
			decode_mv = 12'h76c + 12'(low4 * 12'h032);
		end else if (code < 6'h35) begin
			decode_mv = 12'ha8c + 12'(low4 * 12'h032);
		end else if (code < `RVC_CLAMP_CODE) begin
			decode_mv = 12'hbb8 + 12'((low4 - 12'h005) * 12'h064);
		end else begin
			decode_mv = `RVC_MV_MAX;
		end
	endfunction

	assign o_mv = decode_mv(i_code);

endmodule // rvc_second_linear_regulator_decode

// ==== tb/rvc_host_model.sv ====
// Host-side model driving the decoded byte write and read port.
// Assumes the bench calls wr and rd; signals change only on i_clk.
`timescale 1ns/1ps

module rvc_host_model (
	input  wire logic       i_clk,
	output logic            o_wr_en,
	output logic            o_wr_permit,
	output logic [7:0]      o_wr_addr,
	output logic [7:0]      o_wr_data,
	output logic            o_rd_en,
	output logic [7:0]      o_rd_addr
);
	initial begin
		{o_wr_en, o_wr_permit, o_rd_en} = 3'h0;
		{o_wr_addr, o_wr_data, o_rd_addr} = 24'h000000;
	end
	// Unlock level held only with the strobe, as a careful host would
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic p);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_wr_permit <= p;
		o_wr_addr <= a;
		o_wr_data <= d;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wr_permit <= 1'b0;
		// Released bus shows inverted data, not stale data
		o_wr_addr <= ~a;
		o_wr_data <= ~d;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_rd_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		o_rd_addr <= ~a;
	endtask
endmodule // rvc_host_model

// ==== tb/rvc_top_bench.sv ====
// Self-checking bench for the second-regulator register slice.
// Assumes rvc_host_model drives the port; one 250 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	bad_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module rvc_top_bench;
	localparam logic [7:0] SW3_RST = 8'h5a;
	logic clk = 1'b0, rst_n = 1'b0;
	logic wr_en, wr_permit, rd_en, rd_valid, tracking;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, sw3;
	logic [11:0] conv_mv = 12'h9c4, mv;
	logic [5:0] code;
	int bad_count = 0, checks_done = 0;
	always #2 clk = ~clk;
	rvc_host_model u_host (.i_clk(clk), .o_wr_en(wr_en),
		.o_wr_permit(wr_permit), .o_wr_addr(wr_addr),
		.o_wr_data(wr_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr));
	rvc_top #(.SW3_RESET(SW3_RST)) u_dut (.i_ref_clk(clk),
		.i_rst_n(rst_n), .i_wr_en(wr_en), .i_wr_permit(wr_permit),
		.i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_en(rd_en),
		.i_rd_addr(rd_addr), .i_converter3_mv(conv_mv),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_tracking(tracking), .o_regulator2_voltage_code(code),
		.o_regulator2_mv(mv), .o_switch_or_regulator3_ctrl(sw3));
	// Setpoint in mV for each code, tracking off
	function automatic logic [11:0] exp_mv(input int c);
		if (c < 16) return 12'(900 + 25 * c);
		if (c < 24) return 12'(1300 + 25 * (c - 16));
		if (c < 32) return 12'(1500 + 50 * (c - 24));
		if (c < 48) return 12'(1900 + 50 * (c - 32));
		if (c < 53) return 12'(2700 + 50 * (c - 48));
		if (c < 56) return 12'(3000 + 100 * (c - 53));
		return 12'hce4;
	endfunction
	// Read answer stands just after the taking edge, the same edge that samples rd_en
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a);
		#1;
		`CHK(rd_valid, 1'b1)
		`CHK(rd_data, e)
		// Valid is a one-cycle pulse; data holds until the next read
		@(posedge clk);
		#1;
		`CHK(rd_valid, 1'b0)
		`CHK(rd_data, e)
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK(mv, 12'hce4)
		`CHK(tracking, 1'b0)
		rd_chk(8'h13, 8'h38);
		rd_chk(8'h14, SW3_RST);
		rd_chk(8'h12, 8'h00);
		// Locked writes must leave both registers alone
		u_host.wr(8'h13, 8'h05, 1'b0);
		u_host.wr(8'h14, 8'ha5, 1'b0);
		rd_chk(8'h13, 8'h38);
		rd_chk(8'h14, SW3_RST);
		u_host.wr(8'h14, 8'ha5, 1'b1);
		#1;
		`CHK(sw3, 8'ha5)
		rd_chk(8'h14, 8'ha5);
		// Every code, tracking off, setpoint from the code alone
		for (int c = 0; c < 64; c++) begin
			u_host.wr(8'h13, 8'(c), 1'b1);
			@(posedge clk);
			#1;
			`CHK(code, 6'(c))
			`CHK(mv, exp_mv(c))
		end
		u_host.wr(8'h13, 8'hff, 1'b1);
		@(posedge clk);
		#1;
		`CHK(tracking, 1'b1)
		`CHK(mv, conv_mv)
		rd_chk(8'h13, 8'h7f);
		@(posedge clk);
		conv_mv <= 12'h4b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(mv, 12'h4b0)
		// Mid-run reset while tracking, driven on the edge like any input
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(mv, 12'hce4)
		`CHK(tracking, 1'b0)
		`CHK(sw3, SW3_RST)
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(8'h13, 8'h38);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end
endmodule // rvc_top_bench
